// ==== rtl/line_rx_pkg.sv ====
// Constants, types and register map of the receive output stage
package line_rx_pkg;
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h08;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h0c;
  localparam int IRQ_LOS_SET = 0;
  localparam int IRQ_LOS_CLR = 1;
  localparam int IRQ_VIOL = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam int SYNC_W = 4;
  localparam int BIT_DIV_DEFAULT = 10;
  localparam int LOS_SET_CYCLES_DEFAULT = 1750;
  localparam int LOS_CLR_WINDOW_DEFAULT = 320;
  localparam int LOS_CLR_PULSES_DEFAULT = 4;
  typedef enum logic [1:0] {
    MODE_CLOCK_REC = 2'b00,
    MODE_DATA_REC = 2'b01,
    MODE_UNIPOLAR = 2'b11
  } rx_mode_t;
  typedef struct packed {
    logic alarm_insert_enable;
    rx_mode_t mode;
  } global_control_t;
  localparam global_control_t CTRL_RESET = 3'h0;
  typedef enum logic {
    ST_IN_SERVICE = 1'b0,
    ST_SIGNAL_LOST = 1'b1
  } los_state_t;
  typedef struct packed {
    logic pos;
    logic neg;
  } pulse_pair_t;
endpackage : line_rx_pkg

// ==== rtl/line_receive_output_select.sv ====
// Receive output stage: clock recovery, output formats, loss of signal, alarm insert, APB
//
// Design decisions made here: the address map and the APB interface to the registers.
module line_receive_output_select #(
  parameter int BIT_DIV = line_rx_pkg::BIT_DIV_DEFAULT,
  parameter int LOS_SET_CYCLES = line_rx_pkg::LOS_SET_CYCLES_DEFAULT,
  parameter int LOS_CLR_WINDOW = line_rx_pkg::LOS_CLR_WINDOW_DEFAULT,
  parameter int LOS_CLR_PULSES = line_rx_pkg::LOS_CLR_PULSES_DEFAULT
) (
  input wire logic pclk, // 20 MHz clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic pos_pulse_in, // Slicer positive pulse
  input wire logic neg_pulse_in, // Slicer negative pulse
  input wire logic master_clk_in, // Master reference clock pin
  input wire logic edge_select_in, // Output edge and polarity select
  output logic rclk_out, // Recovered clock
  output logic rclk_oe_n, // Recovered clock drive enable, low drives
  output logic rx_positive_out, // Positive data or unipolar data
  output logic rx_positive_oe_n, // Positive output enable, low drives
  output logic rx_negative_out, // Negative data or violation
  output logic rx_negative_oe_n, // Negative output enable, low drives
  output logic violation_flag_out, // Unipolar violation flag
  output logic signal_loss_flag, // Loss of signal
  output logic irq // Level interrupt
);
  localparam int HALF = BIT_DIV / 2;
  localparam int CW = 16;

  logic [line_rx_pkg::SYNC_W-1:0] sync1_r, sync2_r, sync3_r, filt_r, prev_r;
  line_rx_pkg::pulse_pair_t line_f, pend_r, bit_r, out_src;
  logic mclk_f, edge_f, pos_evt, neg_evt, pulse_evt;
  logic [CW-1:0] div_cnt_r, quiet_cnt_r, win_cnt_r, win_pulses_r;
  logic bit_end, upd_en, rec_clk;
  logic last_pos_r, seen_r, viol_now, viol_bit_r, viol_src, ais_pol_r, ais_on;
  line_rx_pkg::los_state_t los_state_r;
  line_rx_pkg::global_control_t ctrl_r;
  logic [line_rx_pkg::IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_evt;
  logic rclk_nxt, pos_nxt, neg_nxt, viol_nxt;
  logic wr_en, rd_en, addr_ok, los_rise, los_fall;

  // Three-stage synchroniser; a level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end
    else
    begin
      sync1_r <= {edge_select_in, master_clk_in, neg_pulse_in, pos_pulse_in};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < line_rx_pkg::SYNC_W; gi++)
    begin : g_filt
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          filt_r[gi] <= 1'b0;
        else if (sync2_r[gi] == sync3_r[gi])
          filt_r[gi] <= sync3_r[gi];
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_r <= '0;
    else
      prev_r <= filt_r;
  end

  assign line_f = {filt_r[0], filt_r[1]};
  assign mclk_f = filt_r[2];
  assign edge_f = filt_r[3];
  assign pos_evt = filt_r[0] & ~prev_r[0];
  assign neg_evt = filt_r[1] & ~prev_r[1];
  assign pulse_evt = pos_evt | neg_evt;

  // Bit timing: a pulse re-aligns the divider, the clock is high in the first half
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt_r <= '0;
    else if (pulse_evt || div_cnt_r == CW'(BIT_DIV - 1))
      div_cnt_r <= '0;
    else
      div_cnt_r <= div_cnt_r + 1'b1;
  end

  // A pulse in the last cycle of a bit still closes that bit and opens the next
  assign bit_end = div_cnt_r == CW'(BIT_DIV - 1);
  assign rec_clk = div_cnt_r < CW'(HALF);
  // Data changes on the edge opposite the one the far end samples
  assign upd_en = edge_f ? (div_cnt_r == CW'(HALF - 1)) : bit_end;

  // Violation: two marks in a row of the same polarity, in service only
  assign viol_now = seen_r && los_state_r == line_rx_pkg::ST_IN_SERVICE &&
    ((pend_r.pos && last_pos_r) || (pend_r.neg && !last_pos_r));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_r <= '0;
      bit_r <= '0;
      last_pos_r <= 1'b0;
      seen_r <= 1'b0;
      viol_bit_r <= 1'b0;
    end
    else
    begin
      if (bit_end)
      begin
        bit_r <= pend_r;
        viol_bit_r <= viol_now;
        if (pend_r.pos || pend_r.neg)
        begin
          last_pos_r <= pend_r.pos;
          seen_r <= 1'b1;
        end
        pend_r <= {pos_evt, neg_evt};
      end
      else
        pend_r <= pend_r | {pos_evt, neg_evt};
    end
  end

  assign out_src = edge_f ? bit_r : pend_r;
  assign viol_src = edge_f ? viol_bit_r : viol_now;

  // Loss of signal detector
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      los_state_r <= line_rx_pkg::ST_IN_SERVICE;
      quiet_cnt_r <= '0;
      win_cnt_r <= '0;
      win_pulses_r <= '0;
    end
    else
    begin
      case (los_state_r)
        line_rx_pkg::ST_IN_SERVICE:
        begin
          win_cnt_r <= '0;
          win_pulses_r <= '0;
          if (pulse_evt)
            quiet_cnt_r <= '0;
          else if (quiet_cnt_r == CW'(LOS_SET_CYCLES - 1))
            los_state_r <= line_rx_pkg::ST_SIGNAL_LOST;
          else
            quiet_cnt_r <= quiet_cnt_r + 1'b1;
        end
        line_rx_pkg::ST_SIGNAL_LOST:
        begin
          quiet_cnt_r <= '0;
          if (win_cnt_r == CW'(LOS_CLR_WINDOW - 1))
          begin
            win_cnt_r <= '0;
            win_pulses_r <= '0;
            if (win_pulses_r >= CW'(LOS_CLR_PULSES))
              los_state_r <= line_rx_pkg::ST_IN_SERVICE;
          end
          else
          begin
            win_cnt_r <= win_cnt_r + 1'b1;
            if (pulse_evt)
              win_pulses_r <= win_pulses_r + 1'b1;
          end
        end
        default:
          los_state_r <= line_rx_pkg::ST_IN_SERVICE;
      endcase
    end
  end

  assign ais_on = los_state_r == line_rx_pkg::ST_SIGNAL_LOST && ctrl_r.alarm_insert_enable;

  // Alarm pattern is all ones: alternating marks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ais_pol_r <= 1'b0;
    else if (upd_en)
      ais_pol_r <= ~ais_pol_r;
  end

  // Output selection by mode
  always_comb
  begin
    rclk_nxt = rclk_out;
    pos_nxt = rx_positive_out;
    neg_nxt = rx_negative_out;
    viol_nxt = violation_flag_out;
    case (ctrl_r.mode)
      line_rx_pkg::MODE_DATA_REC:
      begin
        rclk_nxt = line_f.pos ^ line_f.neg;
        pos_nxt = edge_f ? line_f.pos : ~line_f.pos;
        neg_nxt = edge_f ? line_f.neg : ~line_f.neg;
        viol_nxt = 1'b0;
      end
      line_rx_pkg::MODE_UNIPOLAR:
      begin
        rclk_nxt = signal_loss_flag ? mclk_f : rec_clk;
        if (upd_en)
        begin
          pos_nxt = ais_on | out_src.pos | out_src.neg;
          viol_nxt = viol_src & ~ais_on;
          neg_nxt = viol_src & ~ais_on;
        end
      end
      default:
      begin
        rclk_nxt = signal_loss_flag ? mclk_f : rec_clk;
        viol_nxt = 1'b0;
        if (upd_en)
        begin
          pos_nxt = ais_on ? ais_pol_r : out_src.pos;
          neg_nxt = ais_on ? ~ais_pol_r : out_src.neg;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rclk_out <= 1'b0;
      rx_positive_out <= 1'b0;
      rx_negative_out <= 1'b0;
      violation_flag_out <= 1'b0;
      rclk_oe_n <= 1'b1;
      rx_positive_oe_n <= 1'b1;
      rx_negative_oe_n <= 1'b1;
      signal_loss_flag <= 1'b0;
    end
    else
    begin
      rclk_out <= rclk_nxt;
      rx_positive_out <= pos_nxt;
      rx_negative_out <= neg_nxt;
      violation_flag_out <= viol_nxt;
      rclk_oe_n <= ~mclk_f;
      rx_positive_oe_n <= ~mclk_f;
      rx_negative_oe_n <= ~mclk_f;
      signal_loss_flag <= los_state_r == line_rx_pkg::ST_SIGNAL_LOST;
    end
  end

  // APB slave, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign addr_ok = paddr == line_rx_pkg::CTRL_ADDR || paddr == line_rx_pkg::STATUS_ADDR ||
    paddr == line_rx_pkg::IRQ_STAT_ADDR || paddr == line_rx_pkg::IRQ_MASK_ADDR;
  assign pslverr = psel && penable && !addr_ok;
  assign los_rise = (los_state_r == line_rx_pkg::ST_SIGNAL_LOST) && !signal_loss_flag;
  assign los_fall = (los_state_r == line_rx_pkg::ST_IN_SERVICE) && signal_loss_flag;
  assign irq_evt = {viol_src && upd_en && ctrl_r.mode != line_rx_pkg::MODE_DATA_REC,
    los_fall, los_rise};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= line_rx_pkg::CTRL_RESET;
      irq_mask_r <= line_rx_pkg::IRQ_RESET;
    end
    else if (wr_en && paddr == line_rx_pkg::CTRL_ADDR)
      ctrl_r <= pwdata[2:0];
    else if (wr_en && paddr == line_rx_pkg::IRQ_MASK_ADDR)
      irq_mask_r <= pwdata[line_rx_pkg::IRQ_W-1:0];
  end

  // Sticky status: a new event wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_r <= line_rx_pkg::IRQ_RESET;
    else if (wr_en && paddr == line_rx_pkg::IRQ_STAT_ADDR)
      irq_stat_r <= (irq_stat_r & ~pwdata[line_rx_pkg::IRQ_W-1:0]) | irq_evt;
    else
      irq_stat_r <= irq_stat_r | irq_evt;
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (rd_en && !penable)
    begin
      case (paddr)
        line_rx_pkg::CTRL_ADDR: prdata <= {29'h0, ctrl_r};
        line_rx_pkg::STATUS_ADDR: prdata <= {28'h0, edge_f, mclk_f, signal_loss_flag, ais_on};
        line_rx_pkg::IRQ_STAT_ADDR: prdata <= {29'h0, irq_stat_r};
        line_rx_pkg::IRQ_MASK_ADDR: prdata <= {29'h0, irq_mask_r};
        default: prdata <= '0;
      endcase
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_rclk_tristate: assert property (!mclk_f |=> rclk_oe_n)
    else $error("recovered clock driven while reference low");
  a_data_tristate: assert property (!mclk_f |=> rx_positive_oe_n && rx_negative_oe_n)
    else $error("data outputs driven while reference low");
  a_los_clock_switch: assert property ((signal_loss_flag &&
    ctrl_r.mode != line_rx_pkg::MODE_DATA_REC) ##1 $stable(ctrl_r) |-> rclk_out == $past(mclk_f))
    else $error("recovered clock not switched to reference");
  a_xor_clock: assert property ((ctrl_r.mode == line_rx_pkg::MODE_DATA_REC) ##1 $stable(ctrl_r)
    |-> rclk_out == ($past(line_f.pos) ^ $past(line_f.neg)))
    else $error("data recovery clock is not the XOR");
  a_rz_polarity: assert property ((ctrl_r.mode == line_rx_pkg::MODE_DATA_REC) ##1 $stable(ctrl_r)
    |-> rx_positive_out == ($past(edge_f) ? $past(line_f.pos) : !$past(line_f.pos)))
    else $error("RZ output polarity wrong");
  a_nrz_edge: assert property (ctrl_r.mode == line_rx_pkg::MODE_CLOCK_REC && $stable(ctrl_r) &&
    $changed(rx_positive_out) |-> $past(upd_en))
    else $error("NRZ output changed off the selected edge");
  a_nrz_mark: assert property (ctrl_r.mode == line_rx_pkg::MODE_CLOCK_REC && upd_en && !ais_on &&
    out_src.neg |=> rx_negative_out)
    else $error("negative mark not shown");
  a_unipolar_viol: assert property (ctrl_r.mode == line_rx_pkg::MODE_UNIPOLAR && upd_en &&
    viol_src && !ais_on |=> violation_flag_out)
    else $error("violation not flagged");
  a_ais_insert: assert property (ctrl_r.mode == line_rx_pkg::MODE_CLOCK_REC && upd_en && ais_on
    |=> rx_positive_out != rx_negative_out)
    else $error("alarm pattern not inserted");
  a_los_set: assert property (los_state_r == line_rx_pkg::ST_IN_SERVICE && !pulse_evt &&
    quiet_cnt_r == CW'(LOS_SET_CYCLES - 1) |=> ##1 signal_loss_flag)
    else $error("loss flag not raised on quiet line");

  c_los_enter: cover property (los_rise);
  c_los_leave: cover property (los_fall);
  c_ais_active: cover property (ais_on && upd_en);
  c_violation: cover property (irq_evt[line_rx_pkg::IRQ_VIOL]);
endmodule : line_receive_output_select

// ==== tb/rx_framer_model.sv ====
// Framer-side model that samples recovered receive data
module rx_framer_model (
  input wire logic rclk_out, // Recovered clock
  input wire logic rclk_oe_n, // Clock drive enable, low drives
  input wire logic edge_select_in, // Chosen sampling edge
  input wire logic rx_positive_out, // Receive data
  output int mark_count // Marks sampled
);
  timeunit 1ns;
  timeprecision 1ns;
  initial mark_count = 0;
  // Sample only on the edge that edge select names, never while undriven
  always @(posedge rclk_out)
  begin
    if (edge_select_in === 1'b1 && rclk_oe_n === 1'b0 && rx_positive_out === 1'b1)
      mark_count++;
  end
  always @(negedge rclk_out)
  begin
    if (edge_select_in === 1'b0 && rclk_oe_n === 1'b0 && rx_positive_out === 1'b1)
      mark_count++;
  end
endmodule : rx_framer_model

// ==== tb/line_receive_output_select_tb.sv ====
// Testbench for the receive output stage
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module line_receive_output_select_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, pos_pulse_in = 0, neg_pulse_in = 0;
  logic master_clk_in = 0, edge_select_in = 0, rclk_out, rclk_oe_n;
  logic rx_positive_out, rx_positive_oe_n, rx_negative_out, rx_negative_oe_n;
  logic violation_flag_out, signal_loss_flag, irq;
  int miscompares = 0, tests_run = 0, mark_count, snap;
  always #25 pclk = ~pclk;
  line_receive_output_select #(.LOS_SET_CYCLES(80), .LOS_CLR_WINDOW(40), .LOS_CLR_PULSES(2)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pos_pulse_in(pos_pulse_in), .neg_pulse_in(neg_pulse_in), .master_clk_in(master_clk_in),
    .edge_select_in(edge_select_in), .rclk_out(rclk_out), .rclk_oe_n(rclk_oe_n),
    .rx_positive_out(rx_positive_out), .rx_positive_oe_n(rx_positive_oe_n),
    .rx_negative_out(rx_negative_out), .rx_negative_oe_n(rx_negative_oe_n),
    .violation_flag_out(violation_flag_out), .signal_loss_flag(signal_loss_flag), .irq(irq));
  rx_framer_model framer (.rclk_out(rclk_out), .rclk_oe_n(rclk_oe_n),
    .edge_select_in(edge_select_in), .rx_positive_out(rx_positive_out), .mark_count(mark_count));
  task give_verdict();
    $display("Counts: %0d checks, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  // One APB transfer; the request is held until pready is seen high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin miscompares++; $display("ERROR pready never seen"); give_verdict(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One bit period on the line: a half-bit mark of the given polarity
  task mark(input logic p);
    @(posedge pclk);
    pos_pulse_in <= p;
    neg_pulse_in <= !p;
    repeat (5) @(posedge pclk);
    pos_pulse_in <= 1'b0;
    neg_pulse_in <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : mark
  function automatic logic probe(input int k);
    case (k)
      0: return rx_positive_out === 1'b1;
      1: return rx_negative_out === 1'b1;
      2: return signal_loss_flag === 1'b1;
      3: return signal_loss_flag === 1'b0;
      default: return violation_flag_out === 1'b1;
    endcase
  endfunction : probe
  task wait_for(input int k, input int lim);
    int n;
    for (n = 0; n < lim; n++)
    begin
      @(posedge pclk);
      #1;
      if (probe(k)) break;
    end
    if (n == lim) begin miscompares++; $display("ERROR wait %0d timed out", k); give_verdict(); end
  endtask : wait_for
  task oe_check(input logic e);
    `CHK("rclk_oe_n", e, rclk_oe_n)
    `CHK("rx_positive_oe_n", e, rx_positive_oe_n)
    `CHK("rx_negative_oe_n", e, rx_negative_oe_n)
  endtask : oe_check
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, line_rx_pkg::CTRL_ADDR, 0);
    `CHK("control reset", 32'h0, rd)
    apb(0, 8'h10, 0);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    oe_check(1'b1);
    $display("Test reset and tristate done");
    master_clk_in <= 1'b1;
    edge_select_in <= 1'b1;
    apb(1, line_rx_pkg::IRQ_MASK_ADDR, 32'h7);
    repeat (8) @(posedge pclk);
    oe_check(1'b0);
    wait_for(2, 200);
    apb(0, line_rx_pkg::IRQ_STAT_ADDR, 0);
    `CHK("loss set event", 1'b1, rd[0])
    `CHK("irq raised", 1'b1, irq)
    apb(1, line_rx_pkg::IRQ_MASK_ADDR, 32'h0);
    #1;
    `CHK("irq masked", 1'b0, irq)
    apb(1, line_rx_pkg::IRQ_MASK_ADDR, 32'h7);
    $display("Test loss raise done");
    apb(1, line_rx_pkg::CTRL_ADDR, 32'h4);
    apb(0, line_rx_pkg::STATUS_ADDR, 0);
    `CHK("status in alarm", 32'hf, rd)
    wait_for(0, 60);
    wait_for(1, 60);
    apb(1, line_rx_pkg::CTRL_ADDR, 32'h0);
    repeat (30) @(posedge pclk);
    `CHK("quiet data in loss", 1'b0, rx_positive_out)
    `CHK("reference clock in loss", 1'b1, rclk_out)
    $display("Test alarm insert done");
    mark(1'b1);
    wait_for(0, 40);
    mark(1'b0);
    wait_for(1, 40);
    apb(1, line_rx_pkg::CTRL_ADDR, 32'h3);
    repeat (3) begin mark(1'b1); mark(1'b0); end
    wait_for(3, 40);
    apb(0, line_rx_pkg::IRQ_STAT_ADDR, 0);
    `CHK("loss clear event", 1'b1, rd[1])
    apb(1, line_rx_pkg::IRQ_STAT_ADDR, 32'h7);
    repeat (15) @(posedge pclk);
    snap = mark_count;
    mark(1'b1);
    mark(1'b1);
    wait_for(4, 40);
    repeat (20) @(posedge pclk);
    `CHK("unipolar marks", 2, mark_count - snap)
    apb(0, line_rx_pkg::IRQ_STAT_ADDR, 0);
    `CHK("violation event", 1'b1, rd[2])
    apb(1, line_rx_pkg::IRQ_STAT_ADDR, 32'h7);
    apb(0, line_rx_pkg::IRQ_STAT_ADDR, 0);
    `CHK("status cleared", 32'h0, rd)
    edge_select_in <= 1'b0;
    apb(1, line_rx_pkg::CTRL_ADDR, 32'h2);
    snap = mark_count;
    mark(1'b1);
    repeat (30) @(posedge pclk);
    `CHK("falling edge marks", 1, mark_count - snap)
    $display("Test clock recovery and unipolar done");
    edge_select_in <= 1'b1;
    apb(1, line_rx_pkg::CTRL_ADDR, 32'h1);
    repeat (5) @(posedge pclk);
    pos_pulse_in <= 1'b1;
    wait_for(0, 40);
    `CHK("xor clock", 1'b1, rclk_out)
    @(posedge pclk);
    pos_pulse_in <= 1'b0;
    edge_select_in <= 1'b0;
    repeat (30) @(posedge pclk);
    `CHK("active low idle", 1'b1, rx_positive_out)
    master_clk_in <= 1'b0;
    repeat (8) @(posedge pclk);
    oe_check(1'b1);
    $display("Test data recovery done");
    give_verdict();
  end
endmodule : line_receive_output_select_tb
